// *** shared/adsc_defs.vh ***
/*
  constants for the converter sequencing block: control word fields,
  pin configuration codes, state codes and timing counts.
  assumes a 200 MHz system clock and plain Verilog-2005 tools.
*/
// Summary of operation
// - four bit-clock sources: 2x, 8x, 1x oscillator, rc
// - only rc timebase continues converting during sleep
// - pin config 03h makes shared pins digital
// - channel change mid-conversion waits for conversion end
// - end clears go, sets done, may interrupt
// - clearing go aborts conversion, back to tracking
// - result written only at conversion completion or by a software write
// - two-bit field picks analog or digital pins
// - analog pin: input buffer off, reads zero
// - analog pin: direction bit still drives output
// - digital pin still feeds converter input
// - track-and-hold: switch opens when conversion begins
`ifndef ADSC_DEFS_VH
`define ADSC_DEFS_VH

// control word field positions
`define ADSC_CTL_CLK_HI 7
`define ADSC_CTL_CLK_LO 6
`define ADSC_CTL_CH_HI 4
`define ADSC_CTL_CH_LO 3
`define ADSC_CTL_GO 2
`define ADSC_CTL_DONE 1
`define ADSC_CTL_PWR 0

// clock source codes
`define ADSC_CLK_OSC2 2'h0
`define ADSC_CLK_OSC8 2'h1
`define ADSC_CLK_OSC1 2'h2
`define ADSC_CLK_RC 2'h3

// reset values and the all-digital pin config code
`define ADSC_CTL_RESET 8'h00
`define ADSC_PCFG_RESET 2'h0
`define ADSC_RES_RESET 8'h00
`define ADSC_PCFG_DIGITAL 2'h3

// sequencer states
`define ADSC_ST_OFF 2'h0
`define ADSC_ST_TRACK 2'h1
`define ADSC_ST_CONV 2'h2

// bit periods per conversion: one to open switch plus one per result bit
`define ADSC_CONV_PERIODS 4'h9

// rc timebase period in ns and derived cycle count at 5 ns per cycle
`define ADSC_RC_PERIOD_NS 2000
`define ADSC_CLK_PERIOD_NS 5
`define ADSC_RC_CYCLES (`ADSC_RC_PERIOD_NS / `ADSC_CLK_PERIOD_NS)

`endif

// *** core/adsc_tick_gen.v ***
/*
  bit-period tick generator: one-cycle enable per conversion bit period.
  assumes osc_tick is a one-cycle pulse per oscillator period and that
  the rc divider counts on ref_clk while run is high, regardless of core sleep.
*/
`timescale 1ns/1ps
`include "adsc_defs.vh"

module adsc_tick_gen #(
  parameter RC_CYCLES = `ADSC_RC_CYCLES
) (
  input wire ref_clk, // system clock
  input wire nrst, // async reset, active low
  input wire run, // divider runs while high
  input wire [1:0] clk_sel, // bit-clock source
  input wire osc_tick, // one pulse per oscillator period
  input wire sleep_mode, // core asleep: oscillator ticks gated
  output wire bit_tick // one pulse per bit period
);
  reg [2:0] osc_cnt_reg;
  reg [15:0] rc_cnt_reg;
  wire osc_ok;
  wire rc_wrap;
  reg osc_bit;

  // oscillator ticks vanish in sleep; the rc divider does not
  assign osc_ok = osc_tick & ~sleep_mode;
  assign rc_wrap = (rc_cnt_reg == RC_CYCLES - 1);

  // oscillator prescaler counts periods for the 2x and 8x choices
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_reg <= 3'h0;
    end else if (!run) begin
      osc_cnt_reg <= 3'h0;
    end else if (osc_ok) begin
      osc_cnt_reg <= osc_cnt_reg + 3'h1;
    end
  end

  // internal rc timebase divider
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rc_cnt_reg <= 16'h0000;
    end else if (!run || rc_wrap) begin
      rc_cnt_reg <= 16'h0000;
    end else begin
      rc_cnt_reg <= rc_cnt_reg + 16'h0001;
    end
  end

  // source select
  always @* begin
    case (clk_sel)
      `ADSC_CLK_OSC2: osc_bit = osc_ok & osc_cnt_reg[0];
      `ADSC_CLK_OSC8: osc_bit = osc_ok & (osc_cnt_reg == 3'h7);
      `ADSC_CLK_OSC1: osc_bit = osc_ok;
      default: osc_bit = 1'b0;
    endcase
  end

  assign bit_tick = run & ((clk_sel == `ADSC_CLK_RC) ? rc_wrap : osc_bit);
endmodule

// *** core/adsc_seq.v ***
/*
  converter sequencing control: control word, result storage, track and
  convert sequencer, done flag, interrupt request and shared pin logic.
  assumes the analog comparator answers comp_hi within one cycle of each
  trial code, and software writes arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
`include "adsc_defs.vh"

module adsc_seq #(
  parameter RC_CYCLES = `ADSC_RC_CYCLES,
  parameter RES_W = 8,
  parameter NPINS = 4
) (
  input wire ref_clk, // system clock, 200 MHz
  input wire nrst, // async reset, active low
  input wire osc_tick, // one pulse per oscillator period
  input wire sleep_mode, // core is asleep
  input wire ctl_wr, // write strobe for control word
  input wire [7:0] ctl_wdata, // control word write data
  output wire [7:0] converter_control_register, // control word readback
  input wire pcfg_wr, // write strobe for pin config
  input wire [1:0] pcfg_wdata, // pin config write data
  output wire [1:0] port_config_register, // pin config readback
  input wire res_wr, // software write to result
  input wire [RES_W-1:0] res_wdata, // result write data
  output wire [RES_W-1:0] result_reg, // result readback
  input wire done_interrupt_enable, // enable done interrupt
  output wire done_irq, // interrupt request, level
  output wire [1:0] track_channel, // channel the hold cap follows
  output wire hold_switch_closed, // input switch closed, tracking
  output wire [RES_W-1:0] trial_code, // code to comparator dac
  input wire comp_hi, // input at or above trial code
  output wire [NPINS-1:0] pin_analog, // pin is analog
  output wire [NPINS-1:0] input_buf_en, // digital input buffer on
  input wire [NPINS-1:0] pin_in, // pad input levels
  input wire [NPINS-1:0] port_dir, // direction bits, 1 means input
  input wire [NPINS-1:0] port_latch, // data latch values
  output wire [NPINS-1:0] pin_out, // pad output values
  output wire [NPINS-1:0] pin_oe_n, // pad output enable, low drives
  output reg [NPINS-1:0] port_read // port read value
);
  reg [1:0] clk_sel_reg;
  reg [1:0] ch_reg;
  reg go_reg;
  reg done_reg;
  reg pwr_reg;
  reg [1:0] pcfg_reg;
  reg [RES_W-1:0] res_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] track_ch_reg;
  reg [3:0] bit_cnt_reg;
  reg [RES_W-1:0] sar_reg;
  reg [RES_W-1:0] trial_reg;
  reg [NPINS-1:0] analog_map;
  wire bit_tick;
  wire run;
  wire finish;
  wire abort;
  wire go_set;
  wire go_keep;

  assign run = pwr_reg & (state_reg == `ADSC_ST_CONV);
  // go written high while powered and tracking starts a conversion
  assign go_set = ctl_wr & ctl_wdata[`ADSC_CTL_GO] & pwr_reg & ~go_reg;
  // rewriting go high mid-conversion, e.g. with a new channel, keeps it set
  assign go_keep = go_reg & ctl_wdata[`ADSC_CTL_GO] & ctl_wdata[`ADSC_CTL_PWR];
  // a cleared go, by write or otherwise, or power loss ends the conversion
  assign abort = (state_reg == `ADSC_ST_CONV) &
    ((ctl_wr & ~ctl_wdata[`ADSC_CTL_GO]) | ~pwr_reg | ~go_reg);
  assign finish = (state_reg == `ADSC_ST_CONV) & bit_tick & (bit_cnt_reg == `ADSC_CONV_PERIODS - 4'h1) & ~abort;

  adsc_tick_gen #(
    .RC_CYCLES(RC_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(run),
    .clk_sel(clk_sel_reg),
    .osc_tick(osc_tick),
    .sleep_mode(sleep_mode),
    .bit_tick(bit_tick)
  );

  // control word: clock, channel, go, done and power fields
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_sel_reg <= 2'h0;
      ch_reg <= 2'h0;
      go_reg <= 1'b0;
      done_reg <= 1'b0;
      pwr_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        clk_sel_reg <= ctl_wdata[`ADSC_CTL_CLK_HI:`ADSC_CTL_CLK_LO];
        ch_reg <= ctl_wdata[`ADSC_CTL_CH_HI:`ADSC_CTL_CH_LO];
        pwr_reg <= ctl_wdata[`ADSC_CTL_PWR];
        go_reg <= go_set | go_keep; // clearing go aborts
        done_reg <= ctl_wdata[`ADSC_CTL_DONE];
      end
      if (finish) begin
        go_reg <= 1'b0;
        done_reg <= 1'b1; // set wins over a clearing write
      end else if (state_reg == `ADSC_ST_CONV && !pwr_reg) begin
        go_reg <= 1'b0;
      end
    end
  end

  assign converter_control_register = {clk_sel_reg, 1'b0, ch_reg, go_reg, done_reg, pwr_reg};

  // pin configuration field
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pcfg_reg <= `ADSC_PCFG_RESET;
    end else if (pcfg_wr) begin
      pcfg_reg <= pcfg_wdata;
    end
  end

  assign port_config_register = pcfg_reg;

  // result: plain storage except at conversion end
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      res_reg <= `ADSC_RES_RESET;
    end else if (finish) begin
      res_reg <= comp_hi ? trial_reg : sar_reg; // last bit decided on this tick
    end else if (res_wr) begin
      res_reg <= res_wdata;
    end
  end

  assign result_reg = res_reg;
  assign done_irq = done_reg & done_interrupt_enable;

  // sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ADSC_ST_OFF: if (pwr_reg) state_next = `ADSC_ST_TRACK;
      `ADSC_ST_TRACK: begin
        if (!pwr_reg) begin
          state_next = `ADSC_ST_OFF;
        end else if (go_reg) begin
          state_next = `ADSC_ST_CONV;
        end
      end
      `ADSC_ST_CONV: begin
        if (!pwr_reg) begin
          state_next = `ADSC_ST_OFF;
        end else if (abort || finish) begin
          state_next = `ADSC_ST_TRACK;
        end
      end
      default: state_next = `ADSC_ST_OFF;
    endcase
  end

  // sequencer state, tracked channel and successive approximation
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= `ADSC_ST_OFF;
      track_ch_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      sar_reg <= {RES_W{1'b0}};
      trial_reg <= {RES_W{1'b0}};
    end else begin
      state_reg <= state_next;
      if (state_reg != `ADSC_ST_CONV) begin
        track_ch_reg <= ch_reg; // frozen during conversion
        bit_cnt_reg <= 4'h0;
        sar_reg <= {RES_W{1'b0}};
        trial_reg <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (bit_tick) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg != 4'h0) begin
          // keep the trial bit if input is above, then try the next bit
          sar_reg <= comp_hi ? trial_reg : (trial_reg & ~(trial_reg & ~sar_reg));
          trial_reg <= (comp_hi ? trial_reg : sar_reg) | ((trial_reg & ~sar_reg) >> 1);
        end
      end
    end
  end

  assign track_channel = track_ch_reg;
  assign hold_switch_closed = (state_reg == `ADSC_ST_TRACK);
  assign trial_code = trial_reg;

  // pin configuration decode: 0 all analog, 3 all digital
  always @* begin
    case (pcfg_reg)
      2'h0: analog_map = 4'hF;
      2'h1: analog_map = 4'hB;
      2'h2: analog_map = 4'h3;
      `ADSC_PCFG_DIGITAL: analog_map = 4'h0;
      default: analog_map = 4'h0;
    endcase
  end

  // per-pin buffers and port read
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      assign pin_analog[gi] = analog_map[gi];
      assign input_buf_en[gi] = ~analog_map[gi];
      assign pin_out[gi] = port_latch[gi];
      assign pin_oe_n[gi] = port_dir[gi];
      always @* begin
        port_read[gi] = analog_map[gi] ? 1'b0 : pin_in[gi];
      end
    end
  endgenerate
endmodule

// *** testbench/adsc_seq_props.sv ***
/* checker for the sequencer: flag, result and pin relations.
   assumes one clock domain and bind onto adsc_seq. */
`timescale 1ns/1ps
module adsc_seq_props #(parameter NPINS = 4) (
  input wire ref_clk, // clock
  input wire nrst, // reset, active low
  input wire ctl_wr, // control strobe
  input wire [7:0] converter_control_register, // control word
  input wire res_wr, // result strobe
  input wire [7:0] result_reg, // result
  input wire done_interrupt_enable, // irq enable
  input wire done_irq, // irq request
  input wire hold_switch_closed, // tracking
  input wire [1:0] port_config_register, // pin config
  input wire [NPINS-1:0] pin_analog, // analog map
  input wire [NPINS-1:0] input_buf_en, // input buffers
  input wire [NPINS-1:0] pin_in, // pad levels
  input wire [NPINS-1:0] port_dir, // direction
  input wire [NPINS-1:0] port_latch, // latch
  input wire [NPINS-1:0] pin_out, // pad out
  input wire [NPINS-1:0] pin_oe_n, // pad enable
  input wire [NPINS-1:0] port_read // port read
);
  wire go = converter_control_register[2];
  wire done = converter_control_register[1];
  wire pwr = converter_control_register[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // sequencing relations
  start_opens_a: assert property ($rose(go) && pwr |=> !hold_switch_closed)
    else $error("switch not opened after go");
  end_flags_a: assert property ($rose(done) |-> $fell(go))
    else $error("done without go clear");
  result_src_a: assert property ($changed(result_reg) && !$past(res_wr) |-> $rose(done))
    else $error("result changed outside completion");
  abort_track_a: assert property ($fell(go) && pwr |-> ##[0:1] hold_switch_closed)
    else $error("no return to tracking");
  done_sticky_a: assert property (done && !ctl_wr |=> done)
    else $error("done dropped without write");
  irq_level_a: assert property (done_irq == (done && done_interrupt_enable))
    else $error("irq mismatch");
  // shared pin relations
  analog_zero_a: assert property ((port_read & pin_analog) == 0)
    else $error("analog pin reads nonzero");
  digital_pass_a: assert property ((port_read & ~pin_analog) == (pin_in & ~pin_analog))
    else $error("digital pin read wrong");
  buf_ctl_a: assert property (input_buf_en == ~pin_analog)
    else $error("input buffer wrong");
  pin_drive_a: assert property (pin_out == port_latch && pin_oe_n == port_dir)
    else $error("pin drive wrong");
  all_digital_a: assert property (port_config_register == 2'h3 |-> pin_analog == 0)
    else $error("code 3 left analog pins");
  cover property ($rose(done) && done_irq);
  cover property ($fell(go) && !$rose(done));
  cover property (port_config_register == 2'h3);
endmodule
bind adsc_seq adsc_seq_props #(.NPINS(NPINS)) u_adsc_seq_props (.ref_clk, .nrst, .ctl_wr,
  .converter_control_register, .res_wr, .result_reg, .done_interrupt_enable, .done_irq,
  .hold_switch_closed, .port_config_register, .pin_analog, .input_buf_en, .pin_in,
  .port_dir, .port_latch, .pin_out, .pin_oe_n, .port_read);

// *** testbench/adsc_analog_model.sv ***
/* analog side: four channel levels, hold capacitor, comparator.
   assumes the switch state is sampled on ref_clk. */
`timescale 1ns/1ps
module adsc_analog_model (
  input wire ref_clk, // clock
  input wire [1:0] track_channel, // followed channel
  input wire hold_switch_closed, // switch closed
  input wire [7:0] trial_code, // dac code
  input wire [31:0] ch_level, // four channel levels
  output wire comp_hi // input at or above trial
);
  reg [7:0] held;
  // capacitor follows the channel only while the switch is closed
  always @(posedge ref_clk) begin
    if (hold_switch_closed) held <= ch_level[track_channel*8 +: 8];
  end
  // half-lsb offset: a level equal to the trial keeps the bit
  assign comp_hi = held >= trial_code;
endmodule

// *** testbench/tb_adsc_seq.sv ***
/* bench for the sequencer: clock sources, sleep, abort, channel change,
   result storage and pins. assumes the analog model on the far side. */
`timescale 1ns/1ps
module tb_adsc_seq;
  reg ref_clk = 1'b0;
  reg nrst, sleep_mode, ctl_wr, pcfg_wr, res_wr, ie;
  reg osc_tick = 1'b0;
  reg [7:0] ctl_wdata, res_wdata;
  reg [1:0] pcfg_wdata;
  reg [1:0] oc = 2'h0;
  reg [3:0] pin_in, port_dir, port_latch;
  wire [7:0] ctl, result_reg, trial_code;
  wire [1:0] pcfg, track_channel;
  wire [3:0] pin_analog, buf_en, pin_out, pin_oe_n, port_read;
  wire done_irq, hold, comp_hi;
  wire [31:0] lvl = 32'h3CA55A81;
  integer n_mismatch = 0;
  integer compares = 0;
  integer n, s, p;
  adsc_seq #(.RC_CYCLES(6)) u_adsc_seq (.ref_clk, .nrst, .osc_tick, .sleep_mode, .ctl_wr,
    .ctl_wdata, .converter_control_register(ctl), .pcfg_wr, .pcfg_wdata,
    .port_config_register(pcfg), .res_wr, .res_wdata, .result_reg,
    .done_interrupt_enable(ie), .done_irq, .track_channel, .hold_switch_closed(hold),
    .trial_code, .comp_hi, .pin_analog, .input_buf_en(buf_en), .pin_in, .port_dir,
    .port_latch, .pin_out, .pin_oe_n, .port_read);
  adsc_analog_model u_adsc_analog_model (.ref_clk, .track_channel,
    .hold_switch_closed(hold), .trial_code, .ch_level(lvl), .comp_hi);
  always #2.5 ref_clk = ~ref_clk;
  // oscillator pulse every fourth cycle
  always @(negedge ref_clk) begin
    oc <= oc + 2'h1;
    osc_tick <= (oc == 2'h3);
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] d);
    begin
      @(negedge ref_clk);
      ctl_wdata = d;
      ctl_wr = 1'b1;
      @(negedge ref_clk);
      ctl_wr = 1'b0;
    end
  endtask
  // sampling time after power-on, channel change or conversion
  task settle;
    repeat (1000) @(negedge ref_clk);
  endtask
  task waitd;
    begin
      n = 0;
      while (ctl[1] !== 1'b1 && n < 600) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk(ctl[1], 1'b1);
    end
  endtask
  task t_clk;
    for (s = 0; s < 4; s = s + 1) begin
      p = (s == 0) ? 8 : (s == 1) ? 32 : (s == 2) ? 4 : 6;
      ie = s[0];
      wr({s[1:0], 6'h11});
      settle;
      wr({s[1:0], 6'h15});
      waitd;
      chk(n >= 8 * p && n <= 10 * p + 4, 1);
      chk(result_reg, 8'hA5);
      chk(ctl[2:1], 2'h1);
      chk(done_irq, s[0]);
    end
    $display("t_clk done");
  endtask
  task t_sleep;
    begin
      sleep_mode = 1'b1;
      wr(8'h81);
      settle;
      wr(8'h85);
      repeat (200) @(negedge ref_clk);
      chk(ctl[2:1], 2'h2);
      wr(8'h81);
      chk(hold, 1);
      chk(result_reg, 8'hA5);
      wr(8'hC1);
      settle;
      wr(8'hC5);
      waitd;
      chk(result_reg, 8'h81);
      sleep_mode = 1'b0;
      $display("t_sleep done");
    end
  endtask
  task t_chan;
    begin
      wr(8'hD1);
      settle;
      wr(8'hD5);
      repeat (10) @(negedge ref_clk);
      wr(8'hCD);
      chk(track_channel, 2'h2);
      waitd;
      chk(result_reg, 8'hA5);
      repeat (2) @(negedge ref_clk);
      chk(track_channel, 2'h1);
      $display("t_chan done");
    end
  endtask
  task t_res;
    begin
      wr(8'h00);
      res_wdata = 8'h3C;
      res_wr = 1'b1;
      @(negedge ref_clk);
      res_wr = 1'b0;
      chk(result_reg, 8'h3C);
      wr(8'hC5);
      chk(ctl[2], 0);
      $display("t_res done");
    end
  endtask
  task t_pins;
    for (s = 0; s < 4; s = s + 1) begin
      p = (s == 0) ? 15 : (s == 1) ? 11 : (s == 2) ? 3 : 0;
      pcfg_wdata = s[1:0];
      pcfg_wr = 1'b1;
      @(negedge ref_clk);
      pcfg_wr = 1'b0;
      @(negedge ref_clk);
      chk(pcfg, s[1:0]);
      chk(pin_analog, p[3:0]);
      chk(port_read, ~p[3:0] & pin_in);
      chk({pin_out, pin_oe_n}, 8'hA5);
      chk(buf_en, 4'hF ^ p[3:0]);
    end
    $display("t_pins done");
  endtask
  task close_out;
    begin
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    {nrst, sleep_mode, ctl_wr, pcfg_wr, res_wr, ie} = 6'h0;
    {ctl_wdata, res_wdata, pcfg_wdata} = 18'h0;
    {pin_in, port_dir, port_latch} = 12'hE5A;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    chk(ctl, 8'h00);
    chk(result_reg, 8'h00);
    chk({pin_analog, port_read}, 8'hF0);
    t_clk;
    t_sleep;
    t_chan;
    t_res;
    t_pins;
    close_out;
  end
  // watchdog well beyond the expected run
  initial begin
    #150000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
